/* File: logic/chdp_host_port.sv */
// direct registers of the codec byte-wide host port
// assumes host pins asynchronous to mclk_in; converter side on mclk_in
`timescale 1ns/10ps
`include "chdp_consts.svh"

// What this block does
// - select 1 reads or writes the indirect register chosen by the index pointer
// - while initializing, window writes are dropped and window reads give 80h
// - ready and interrupt bits change freely; host re-reads to see a new one
// - status register reads cch right after reset
// - capture upper/lower reads 0 for pending low byte, else 1 or 8-bit
// - status byte and channel bits name the next capture byte returned
// - select 3 writes go to playback byte, reads come from capture byte
// - while initializing, playback writes are ignored, capture reads give 80h
// - each capture byte read advances the capture byte tracker
// - after all capture bytes are read the pointer stays on the last byte
// - a new capture sample returns pointer and status to the first byte
// - after a full read and before new data, reads repeat the kept byte
// - each playback byte write advances the playback byte tracker
// - once all playback bytes are written, further byte writes are ignored
// - playback tracker returns to first byte when the sample goes out
// - window target is the index most recently written
// - interrupt flag alone is sticky; other status bits follow samples
// - init busy is reported and blocks every register write
module chdp_host_port (
    input  wire logic         mclk_in,
    input  wire logic         reset_in,
    input  wire logic [1:0]   register_select_in,
    input  wire logic         cs_n_in,
    input  wire logic         rd_n_in,
    input  wire logic         wr_n_in,
    input  wire logic [7:0]   data_in,
    output logic [7:0]        data_out,
    output logic              data_oe_out,
    input  wire logic         init_busy_in,
    input  wire logic         interrupt_event_in,
    input  wire logic         sample_overrun_in,
    input  wire logic [31:0]  capture_sample_in,
    input  wire logic         capture_valid_in,
    output logic [31:0]       playback_sample_out,
    output logic              playback_full_out,
    input  wire logic         playback_take_in,
    output logic              int_out,
    output logic              mode_change_out,
    output logic              transfer_disable_out,
    output logic [127:0]      indirect_flat_out
);

    // host bus synchroniser, one vector so all pins age together
    logic [12:0]  bus_s1_reg;
    logic [12:0]  bus_s2_reg;
    logic [12:0]  bus_d_reg;

    logic         now_cs_n;
    logic         now_rd_n;
    logic         now_wr_n;
    logic [1:0]   now_sel;
    logic         old_cs_n;
    logic         old_rd_n;
    logic         old_wr_n;
    logic [1:0]   acc_sel;
    logic [7:0]   acc_data;

    logic         wr_evt;
    logic         rd_evt;
    logic         wr_ok;
    logic         hit_index;
    logic         hit_window;
    logic         hit_status;
    logic         hit_pio;

    logic [3:0]   index_pointer_reg;
    logic         mce_reg;
    logic         trd_reg;
    logic [7:0]   indirect_reg [0:15];

    logic         int_flag_reg;
    logic         capture_ready_reg;
    logic         playback_ready_reg;
    logic [31:0]  cap_buf_reg;
    logic [31:0]  pb_buf_reg;

    logic         fmt_wide;
    logic         fmt_stereo;
    logic         interrupt_pin_enable;

    logic [1:0]   cap_pos;
    logic         cap_at_last;
    logic         cap_read;
    logic [1:0]   pb_pos;
    logic         pb_at_last;
    logic         pb_full;
    logic         pb_write;

    logic [7:0]   status_byte;
    logic [7:0]   index_byte;
    logic [7:0]   read_byte;
    logic [7:0]   data_out_reg;
    logic         data_oe_reg;
    logic         int_out_reg;

    // reset value of indirect register i
    function automatic logic [7:0] ind_reset(input logic [3:0] idx);
        if (idx >= `CHDP_IDX_MUTE_LO && idx <= `CHDP_IDX_MUTE_HI) begin
            ind_reset = `CHDP_IND_MUTED;
        end else begin
            ind_reset = `CHDP_IND_RESET;
        end
    endfunction

    // upper/lower indicator for a byte position
    function automatic logic upper_of(input logic [1:0] pos, input logic wide);
        upper_of = wide ? pos[0] : 1'b1;
    endfunction

    // left/right indicator; left first in each sample
    function automatic logic left_of(input logic [1:0] pos, input logic wide,
                                     input logic stereo);
        if (!stereo) begin
            left_of = 1'b1;
        end else begin
            left_of = wide ? ~pos[1] : ~pos[0];
        end
    endfunction

    // blocked registers read a fixed byte while initializing
    function automatic logic [7:0] gate_init(input logic busy, input logic [7:0] live);
        if (busy) begin
            gate_init = `CHDP_INIT_READ;
        end else begin
            gate_init = live;
        end
    endfunction

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            bus_s1_reg <= `CHDP_BUS_IDLE;
            bus_s2_reg <= `CHDP_BUS_IDLE;
            bus_d_reg  <= `CHDP_BUS_IDLE;
        end else begin
            bus_s1_reg <= {cs_n_in, rd_n_in, wr_n_in, register_select_in, data_in};
            bus_s2_reg <= bus_s1_reg;
            bus_d_reg  <= bus_s2_reg;
        end
    end

    assign now_cs_n = bus_s2_reg[12];
    assign now_rd_n = bus_s2_reg[11];
    assign now_wr_n = bus_s2_reg[10];
    assign now_sel  = bus_s2_reg[9:8];
    assign old_cs_n = bus_d_reg[12];
    assign old_rd_n = bus_d_reg[11];
    assign old_wr_n = bus_d_reg[10];
    assign acc_sel  = bus_d_reg[9:8];
    assign acc_data = bus_d_reg[7:0];

    // accesses complete on the trailing strobe edge, when data is settled
    assign wr_evt = now_wr_n & ~old_wr_n & ~old_cs_n;
    assign rd_evt = now_rd_n & ~old_rd_n & ~old_cs_n;
    assign wr_ok  = wr_evt & ~init_busy_in;

    // selects of the access being committed, one cycle behind the synchronised pins
    assign hit_index  = (acc_sel == `CHDP_SEL_INDEX);
    assign hit_window = (acc_sel == `CHDP_SEL_WINDOW);
    assign hit_status = (acc_sel == `CHDP_SEL_STATUS);
    assign hit_pio    = (acc_sel == `CHDP_SEL_PIO);

    assign fmt_wide   = indirect_reg[`CHDP_IDX_FORMAT][`CHDP_FMT_BIT]
                      & ~indirect_reg[`CHDP_IDX_FORMAT][`CHDP_LC_BIT];
    assign fmt_stereo = indirect_reg[`CHDP_IDX_FORMAT][`CHDP_SM_BIT];
    assign interrupt_pin_enable = indirect_reg[`CHDP_IDX_PINCTL][`CHDP_IEN_BIT];

    // index register
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            index_pointer_reg <= 4'h0;
            mce_reg           <= `CHDP_IX_MCE_RESET;
            trd_reg           <= 1'b0;
        end else if (wr_ok && hit_index) begin
            index_pointer_reg <= acc_data[3:0];
            mce_reg           <= acc_data[`CHDP_IX_MCE_BIT];
            trd_reg           <= acc_data[`CHDP_IX_TRD_BIT];
        end
    end

    // indirect registers behind the window
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            for (int i = 0; i < 16; i++) begin
                indirect_reg[i] <= ind_reset(4'(i));
            end
        end else if (wr_ok && hit_window) begin
            indirect_reg[index_pointer_reg] <= acc_data;
        end
    end

    // interrupt flag: event set beats a same-cycle status write
    // a status write during init is dropped, so a pending flag survives it
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            int_flag_reg <= 1'b0;
        end else if (interrupt_event_in) begin
            int_flag_reg <= 1'b1;
        end else if (wr_ok && hit_status) begin
            int_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            int_out_reg <= 1'b0;
        end else begin
            int_out_reg <= int_flag_reg & interrupt_pin_enable;
        end
    end

    // capture path
    assign cap_read = rd_evt & ~init_busy_in & hit_pio;

    chdp_byte_track u_cap_track (
        .mclk_in      (mclk_in),
        .reset_in     (reset_in),
        .restart_in   (capture_valid_in),
        .advance_in   (cap_read),
        .wide_in      (fmt_wide),
        .stereo_in    (fmt_stereo),
        .byte_pos_out (cap_pos),
        .at_last_out  (cap_at_last),
        .full_out     ()
    );

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            cap_buf_reg <= 32'h0000_0000;
        end else if (capture_valid_in) begin
            cap_buf_reg <= capture_sample_in;
        end
    end

    // a new sample wins over the read that drains the old one
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            capture_ready_reg <= 1'b0;
        end else if (capture_valid_in) begin
            capture_ready_reg <= 1'b1;
        end else if (cap_read && cap_at_last) begin
            capture_ready_reg <= 1'b0;
        end
    end

    // playback path
    assign pb_write = wr_ok & hit_pio & ~pb_full;

    chdp_byte_track u_pb_track (
        .mclk_in      (mclk_in),
        .reset_in     (reset_in),
        .restart_in   (playback_take_in),
        .advance_in   (pb_write),
        .wide_in      (fmt_wide),
        .stereo_in    (fmt_stereo),
        .byte_pos_out (pb_pos),
        .at_last_out  (pb_at_last),
        .full_out     (pb_full)
    );

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pb_buf_reg <= 32'h0000_0000;
        end else if (pb_write) begin
            pb_buf_reg[{pb_pos, 3'h0} +: 8] <= acc_data;
        end
    end

    // converter request sets ready; completing the sample clears it
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            playback_ready_reg <= 1'b0;
        end else if (playback_take_in) begin
            playback_ready_reg <= 1'b1;
        end else if (pb_write && pb_at_last) begin
            playback_ready_reg <= 1'b0;
        end
    end

    // status byte; after reset an 8-bit mono format gives cch
    always_comb begin
        status_byte = 8'h00;
        status_byte[`CHDP_ST_CUL_BIT]  = upper_of(cap_pos, fmt_wide);
        status_byte[`CHDP_ST_CLR_BIT]  = left_of(cap_pos, fmt_wide, fmt_stereo);
        status_byte[`CHDP_ST_CAPTURE_READY_BIT] = capture_ready_reg;
        status_byte[`CHDP_ST_SOUR_BIT] = sample_overrun_in;
        status_byte[`CHDP_ST_PUL_BIT]  = upper_of(pb_pos, fmt_wide);
        status_byte[`CHDP_ST_PLR_BIT]  = left_of(pb_pos, fmt_wide, fmt_stereo);
        status_byte[`CHDP_ST_PLAYBACK_READY_BIT] = playback_ready_reg;
        status_byte[`CHDP_ST_INT_BIT]  = int_flag_reg;
    end

    always_comb begin
        index_byte = {1'b0, mce_reg, trd_reg, 1'b0, index_pointer_reg};
        index_byte[`CHDP_IX_INIT_BIT] = init_busy_in;
    end

    // read mux; pointer parks on last byte so repeats return it
    always_comb begin
        case (now_sel)
            `CHDP_SEL_INDEX: begin
                read_byte = gate_init(init_busy_in, index_byte);
            end
            `CHDP_SEL_WINDOW: begin
                read_byte = gate_init(init_busy_in, indirect_reg[index_pointer_reg]);
            end
            `CHDP_SEL_STATUS: begin
                read_byte = status_byte;
            end
            default: begin
                read_byte = gate_init(init_busy_in,
                                      cap_buf_reg[{cap_pos, 3'h0} +: 8]);
            end
        endcase
    end

    // live bits are re-sampled every cycle of the strobe, so a bit that
    // sets late in a read shows on the next read only
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            data_out_reg <= 8'h00;
            data_oe_reg  <= 1'b0;
        end else begin
            data_out_reg <= read_byte;
            data_oe_reg  <= ~now_rd_n & ~now_cs_n;
        end
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            indirect_flat_out[i*8 +: 8] = indirect_reg[i];
        end
    end

    assign data_out             = data_out_reg;
    assign data_oe_out          = data_oe_reg;
    assign int_out              = int_out_reg;
    assign mode_change_out      = mce_reg;
    assign transfer_disable_out = trd_reg;
    assign playback_sample_out  = pb_buf_reg;
    assign playback_full_out    = pb_full;

endmodule

/* File: pkg/chdp_consts.svh */
// constants of the codec host direct port: selects, fields, reset values
// assumes inclusion by bare name; definitions only
`ifndef CHDP_CONSTS_SVH
`define CHDP_CONSTS_SVH

// register_select values
`define CHDP_SEL_INDEX      2'h0
`define CHDP_SEL_WINDOW     2'h1
`define CHDP_SEL_STATUS     2'h2
`define CHDP_SEL_PIO        2'h3

// value read through blocked registers while initializing
`define CHDP_INIT_READ      8'h80
`define CHDP_STATUS_RESET   8'hcc

// index register fields
`define CHDP_IX_INIT_BIT    7
`define CHDP_IX_MCE_BIT     6
`define CHDP_IX_TRD_BIT     5
`define CHDP_IX_MCE_RESET   1'b1

// host_status fields
`define CHDP_ST_CUL_BIT     7
`define CHDP_ST_CLR_BIT     6
`define CHDP_ST_CAPTURE_READY_BIT    5
`define CHDP_ST_SOUR_BIT    4
`define CHDP_ST_PUL_BIT     3
`define CHDP_ST_PLR_BIT     2
`define CHDP_ST_PLAYBACK_READY_BIT    1
`define CHDP_ST_INT_BIT     0

// indirect registers used by this block
`define CHDP_IDX_FORMAT     4'h8
`define CHDP_IDX_PINCTL     4'ha
`define CHDP_FMT_BIT        6
`define CHDP_LC_BIT         5
`define CHDP_SM_BIT         4
`define CHDP_IEN_BIT        1

// indirect reset values: aux inputs power up muted
`define CHDP_IND_RESET      8'h00
`define CHDP_IND_MUTED      8'h80
`define CHDP_IDX_MUTE_LO    4'h2
`define CHDP_IDX_MUTE_HI    4'h5

// synchronised bus vector {cs_n, rd_n, wr_n, sel[1:0], data[7:0]}
`define CHDP_BUS_IDLE       13'h1c00

`endif

/* File: pkg/chdp_pkg.sv */
// types of the codec host direct port
// assumes chdp_consts.svh for all numeric constants
package chdp_pkg;

    // byte tracking states, gray coded along b0-b1-b2-b3-full
    typedef enum logic [2:0] {
        CHDP_TRK_B0   = 3'h0,
        CHDP_TRK_B1   = 3'h1,
        CHDP_TRK_B2   = 3'h3,
        CHDP_TRK_B3   = 3'h2,
        CHDP_TRK_FULL = 3'h6
    } chdp_trk_state_t;

endpackage

/* File: logic/chdp_byte_track.sv */
// byte tracking state machine for one programmed-I/O direction
// assumes restart and advance are single-cycle pulses on mclk_in
`timescale 1ns/10ps

module chdp_byte_track (
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       restart_in,
    input  wire logic       advance_in,
    input  wire logic       wide_in,
    input  wire logic       stereo_in,
    output logic [1:0]      byte_pos_out,
    output logic            at_last_out,
    output logic            full_out
);

    chdp_pkg::chdp_trk_state_t state_reg;
    chdp_pkg::chdp_trk_state_t state_next;
    logic [1:0]                last_pos;
    logic [1:0]                cur_pos;

    // bytes per sample: 1, 2 or 4
    assign last_pos = {wide_in & stereo_in, wide_in | stereo_in};

    always_comb begin
        case (state_reg)
            chdp_pkg::CHDP_TRK_B0:   cur_pos = 2'h0;
            chdp_pkg::CHDP_TRK_B1:   cur_pos = 2'h1;
            chdp_pkg::CHDP_TRK_B2:   cur_pos = 2'h2;
            chdp_pkg::CHDP_TRK_B3:   cur_pos = 2'h3;
            default:                 cur_pos = last_pos;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        if (advance_in) begin
            if (state_reg == chdp_pkg::CHDP_TRK_FULL) begin
                state_next = chdp_pkg::CHDP_TRK_FULL;
            end else if (cur_pos == last_pos) begin
                state_next = chdp_pkg::CHDP_TRK_FULL;
            end else begin
                case (state_reg)
                    chdp_pkg::CHDP_TRK_B0: state_next = chdp_pkg::CHDP_TRK_B1;
                    chdp_pkg::CHDP_TRK_B1: state_next = chdp_pkg::CHDP_TRK_B2;
                    chdp_pkg::CHDP_TRK_B2: state_next = chdp_pkg::CHDP_TRK_B3;
                    default:               state_next = chdp_pkg::CHDP_TRK_FULL;
                endcase
            end
        end
        // a new sample restarts tracking even if a byte moves this cycle
        if (restart_in) begin
            state_next = chdp_pkg::CHDP_TRK_B0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_reg <= chdp_pkg::CHDP_TRK_B0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign byte_pos_out = cur_pos;
    assign at_last_out  = (state_reg != chdp_pkg::CHDP_TRK_FULL) && (cur_pos == last_pos);
    assign full_out     = (state_reg == chdp_pkg::CHDP_TRK_FULL);

endmodule

/* File: verif/chdp_host_port_checker.sv */
// concurrent checks on the host port pins and converter side
// assumes one clock domain, sync active-high reset, host pins held around strobes
`timescale 1ns/10ps
`include "chdp_consts.svh"

module chdp_host_port_checker (
    input wire logic         mclk_in,
    input wire logic         reset_in,
    input wire logic [1:0]   register_select_in,
    input wire logic         cs_n_in,
    input wire logic         rd_n_in,
    input wire logic [7:0]   data_out,
    input wire logic         data_oe_out,
    input wire logic         init_busy_in,
    input wire logic         interrupt_event_in,
    input wire logic [31:0]  playback_sample_out,
    input wire logic         playback_full_out,
    input wire logic         playback_take_in,
    input wire logic         int_out,
    input wire logic         mode_change_out,
    input wire logic [127:0] indirect_flat_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    logic host_rd;
    assign host_rd = !cs_n_in && !rd_n_in;

    sequence s_read_held;
        host_rd [*3];
    endsequence
    sequence s_int_armed;
        indirect_flat_out[81] && interrupt_event_in;
    endsequence

    chk_read_drive: assert property (s_read_held |-> ##[1:2] data_oe_out)
        else $error("read strobe not answered by bus drive");
    chk_drive_cause: assert property ($rose(data_oe_out) |-> $past(host_rd, 3) || $past(host_rd, 2))
        else $error("bus driven without a read strobe");
    chk_drive_release: assert property ($rose(rd_n_in) |-> ##[2:4] !data_oe_out)
        else $error("bus drive held after read strobe ended");
    chk_int_raise: assert property (s_int_armed |-> ##[1:2] int_out)
        else $error("interrupt pin not raised by enabled event");
    chk_int_gate: assert property (int_out |-> $past(indirect_flat_out[81]))
        else $error("interrupt pin high while pin enable clear");
    chk_init_read: assert property (data_oe_out && init_busy_in && $past(init_busy_in, 4)
        && register_select_in != `CHDP_SEL_STATUS && $stable(register_select_in)
        && $past(register_select_in, 3) == register_select_in
        |-> data_out == `CHDP_INIT_READ)
        else $error("blocked register read not 80h while initializing");
    chk_init_frozen: assert property ($past(init_busy_in)
        |-> $stable(indirect_flat_out) && $stable(mode_change_out))
        else $error("register changed while initializing");
    chk_full_hold: assert property (playback_full_out && !playback_take_in
        |=> $stable(playback_sample_out))
        else $error("playback sample changed while full");
    chk_take_restart: assert property (playback_take_in |=> !playback_full_out)
        else $error("playback tracker not restarted by take");
endmodule

bind chdp_host_port chdp_host_port_checker i_chk (
    .mclk_in(mclk_in), .reset_in(reset_in), .register_select_in(register_select_in),
    .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .init_busy_in(init_busy_in), .interrupt_event_in(interrupt_event_in),
    .playback_sample_out(playback_sample_out), .playback_full_out(playback_full_out),
    .playback_take_in(playback_take_in), .int_out(int_out),
    .mode_change_out(mode_change_out), .indirect_flat_out(indirect_flat_out));

/* File: verif/chdp_host_model.sv */
// host bus controller model: strobed byte accesses on the direct registers
// assumes the device synchronises pins in 2 flops; changes only at falling edge
`timescale 1ns/10ps

module chdp_host_model (
    input  wire logic       mclk_in,
    input  wire logic [7:0] data_in,
    input  wire logic       oe_in,
    output logic [1:0]      sel_out,
    output logic            cs_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic [7:0]      data_out
);
    logic last_oe;

    initial begin
        sel_out = 2'h0;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        data_out = 8'h00;
        last_oe = 1'b0;
    end

    task automatic write_reg(input logic [1:0] sel, input logic [7:0] val);
        @(negedge mclk_in);
        sel_out = sel;
        data_out = val;
        cs_n_out = 1'b0;
        wr_n_out = 1'b0;
        repeat (3) @(negedge mclk_in);
        wr_n_out = 1'b1;
        @(negedge mclk_in);
        cs_n_out = 1'b1;
        data_out = ~val; // released: stale byte must never look valid
        repeat (4) @(negedge mclk_in);
    endtask

    task automatic read_reg(input logic [1:0] sel, output logic [7:0] val);
        @(negedge mclk_in);
        sel_out = sel;
        cs_n_out = 1'b0;
        rd_n_out = 1'b0;
        repeat (5) @(negedge mclk_in);
        val = data_in; // a flag set after this sample is caught only by a later read
        last_oe = oe_in;
        rd_n_out = 1'b1;
        @(negedge mclk_in);
        cs_n_out = 1'b1;
        repeat (4) @(negedge mclk_in);
    endtask
endmodule

/* File: verif/codec_host_direct_port_tb.sv */
// self-checking bench of the host port: registers, init block, pio paths, interrupt
// assumes chdp_host_model as bus partner; converter side driven here
`timescale 1ns/10ps

`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module codec_host_direct_port_tb;
    logic         mclk_in = 1'b0;
    logic         reset_in = 1'b1;
    logic         init_busy_in = 1'b0;
    logic         int_ev = 1'b0;
    logic [31:0]  cap_sample = 32'h0;
    logic         cap_valid = 1'b0;
    logic         take = 1'b0;
    logic         ovr = 1'b0;
    logic         mce;
    logic         trd;
    logic [1:0]   sel;
    logic         cs_n, rd_n, wr_n, oe, full, int_out;
    logic [7:0]   hdata, ddata, rv;
    logic [31:0]  pb_sample;
    logic [127:0] ind;
    int           err_count = 0;
    int           cmp_count = 0;

    always #4 mclk_in = ~mclk_in;

    chdp_host_model i_host (.mclk_in(mclk_in), .data_in(ddata), .oe_in(oe), .sel_out(sel),
        .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(hdata));

    chdp_host_port i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .register_select_in(sel),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(hdata), .data_out(ddata),
        .data_oe_out(oe), .init_busy_in(init_busy_in), .interrupt_event_in(int_ev),
        .sample_overrun_in(ovr), .capture_sample_in(cap_sample),
        .capture_valid_in(cap_valid), .playback_sample_out(pb_sample),
        .playback_full_out(full), .playback_take_in(take), .int_out(int_out),
        .mode_change_out(mce), .transfer_disable_out(trd), .indirect_flat_out(ind));

    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic rd_chk(input logic [1:0] s, input logic [7:0] exp, input logic [7:0] m);
        i_host.read_reg(s, rv);
        `CHECK(i_host.last_oe, 1'b1)
        `CHECK(rv & m, exp)
    endtask

    task automatic t_window();
        i_host.write_reg(2'h0, 8'h43);
        i_host.write_reg(2'h1, 8'h5a);
        i_host.write_reg(2'h0, 8'h49);
        i_host.write_reg(2'h1, 8'h3c);
        i_host.write_reg(2'h0, 8'h23);
        rd_chk(2'h0, 8'h23, 8'hff);
        rd_chk(2'h1, 8'h5a, 8'hff);
        `CHECK(mce, 1'b0)
        `CHECK(trd, 1'b1)
        `CHECK(ind[31:24], 8'h5a)
        `CHECK(ind[79:72], 8'h3c)
    endtask

    task automatic t_init();
        @(negedge mclk_in) init_busy_in = 1'b1;
        rd_chk(2'h1, 8'h80, 8'hff);
        rd_chk(2'h0, 8'h80, 8'hff);
        i_host.write_reg(2'h1, 8'h11);
        rd_chk(2'h3, 8'h80, 8'hff);
        i_host.write_reg(2'h3, 8'h99);
        @(negedge mclk_in) init_busy_in = 1'b0;
        rd_chk(2'h1, 8'h5a, 8'hff);
        `CHECK(pb_sample, 32'h0)
    endtask

    task automatic t_capture();
        logic [31:0] s;
        s = 32'h44332211;
        i_host.write_reg(2'h0, 8'h48);
        i_host.write_reg(2'h1, 8'h50); // 16-bit stereo
        @(negedge mclk_in) cap_sample = s;
        cap_valid = 1'b1;
        @(negedge mclk_in) cap_valid = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd_chk(2'h2, {i[0], i < 2, 6'h20}, 8'he0);
            rd_chk(2'h3, s[8*i +: 8], 8'hff);
        end
        rd_chk(2'h2, 8'h80, 8'he0);
        rd_chk(2'h3, 8'h44, 8'hff);
        @(negedge mclk_in) cap_sample = 32'h88776655;
        cap_valid = 1'b1;
        @(negedge mclk_in) cap_valid = 1'b0;
        rd_chk(2'h2, 8'h60, 8'he0);
        rd_chk(2'h3, 8'h55, 8'hff);
        i_host.write_reg(2'h1, 8'h10); // 8-bit stereo
        @(negedge mclk_in) cap_valid = 1'b1;
        @(negedge mclk_in) cap_valid = 1'b0;
        rd_chk(2'h2, 8'he0, 8'he0);
        rd_chk(2'h3, 8'h55, 8'hff);
        rd_chk(2'h2, 8'ha0, 8'he0);
        rd_chk(2'h3, 8'h66, 8'hff);
        rd_chk(2'h2, 8'h80, 8'he0);
        rd_chk(2'h3, 8'h66, 8'hff);
        i_host.write_reg(2'h1, 8'h50); // back to 16-bit stereo
    endtask

    task automatic t_playback();
        logic [39:0] b;
        b = 40'he5d4c3b2a1;
        for (int i = 0; i < 5; i++) begin
            if (i < 4) rd_chk(2'h2, {4'h0, i[0], i < 2, 2'h0}, 8'h0c);
            i_host.write_reg(2'h3, b[8*i +: 8]);
        end
        `CHECK(full, 1'b1)
        `CHECK(pb_sample, 32'hd4c3b2a1)
        @(negedge mclk_in) take = 1'b1;
        @(negedge mclk_in) take = 1'b0;
        `CHECK(full, 1'b0)
        rd_chk(2'h2, 8'h06, 8'h0e);
        i_host.write_reg(2'h3, 8'hf6);
        `CHECK(pb_sample[7:0], 8'hf6)
    endtask

    task automatic t_interrupt();
        i_host.write_reg(2'h0, 8'h4a);
        i_host.write_reg(2'h1, 8'h02);
        @(negedge mclk_in) int_ev = 1'b1;
        @(negedge mclk_in) int_ev = 1'b0;
        repeat (3) @(negedge mclk_in);
        `CHECK(int_out, 1'b1)
        repeat (20) @(negedge mclk_in);
        rd_chk(2'h2, 8'h01, 8'h01);
        i_host.write_reg(2'h2, 8'h00); // clears the flag
        rd_chk(2'h2, 8'h00, 8'h01);
        `CHECK(int_out, 1'b0)
        @(negedge mclk_in) ovr = 1'b1;
        rd_chk(2'h2, 8'h10, 8'h10);
        @(negedge mclk_in) ovr = 1'b0;
        rd_chk(2'h2, 8'h00, 8'h10);
    endtask

    initial begin
        repeat (10) @(negedge mclk_in);
        reset_in = 1'b0;
        rd_chk(2'h2, 8'hcc, 8'hff);
        t_window();
        t_init();
        t_capture();
        t_playback();
        t_interrupt();
        tally_and_finish();
    end

    initial begin
        #50000; // about ten times the expected run
        err_count++;
        tally_and_finish();
    end
endmodule
